//--- logic/rpc_checker.sv
/*
  range protection checker on a peripheral configuration slave port.
  assumes a single clock, a plain register port with one-cycle strobes,
  a valid-only transfer port facing masters and one facing the slave.
*/
// The address-and-strobe port and the address map are this design's own decisions.
`include "rpc_params.svh"

// Functional notes
// - unmatched addresses pass unchanged and never raise a violation
// - a range checks only ids whose requestor bit is set
// - zero attribute admits all; 0x03FFFC00 refuses all
// - overlapping hits pass only if every hit range permits
// - effective permission is the per-type minimum of hit ranges
// - read-only grant for an id blocks that id's writes
// - register access while peripheral unpowered returns bus error
// - boundaries compare against the low 32 address bits only
// - privilege id selects one of 16 requestor bits
// - unit has 4 ranges with start and end
// - every master's transfer to the slave is screened
module rpc_checker
  import rpc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [`RPC_REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [`RPC_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`RPC_DATA_W-1:0] reg_rdata_o,
  output logic reg_err_o,
  // peripheral power state
  input wire logic periph_powered_i,
  // transfer from masters
  input wire logic xfer_valid_i,
  input rpc_xfer_type xfer_i,
  // transfer to slave
  output logic slv_valid_o,
  output rpc_xfer_type slv_xfer_o,
  output logic xfer_block_o,
  // violation event level
  output logic violation_o
);

  ////////////////////////////////////////////////////////////////////////////
  // storage and decode

  logic [`RPC_ADDR_W-1:0] start_ff [`RPC_NUM_RANGES];
  logic [`RPC_ADDR_W-1:0] end_ff [`RPC_NUM_RANGES];
  logic [`RPC_DATA_W-1:0] attr_ff [`RPC_NUM_RANGES];
  logic [`RPC_NUM_RANGES-1:0] hit;
  logic [`RPC_NUM_RANGES-1:0] permit;
  logic pwr_meta_ff;
  logic pwr_sync_ff;
  logic [`RPC_DATA_W-1:0] reg_rdata_ff;
  logic reg_err_ff;
  logic slv_valid_ff;
  rpc_xfer_type slv_xfer_ff;
  logic block_ff;
  logic violation_ff;
  logic [`RPC_ADDR_W-1:0] fault_addr_ff;
  logic [`RPC_DATA_W-1:0] fault_stat_ff;
  rpc_state_type state_ff;
  logic all_permit;
  logic refuse;
  logic ack_wr;
  logic [`RPC_ADDR_W-1:0] low_addr;

  // whether an address falls inside the range register block
  function automatic logic range_sel(input logic [`RPC_REG_ADDR_W-1:0] a);
    range_sel = (a >= `RPC_RANGE_BASE) && (a < `RPC_RANGE_LIMIT);
  endfunction : range_sel

  // range number from a register address
  function automatic logic [`RPC_RANGE_IDX_W-1:0] range_idx(
      input logic [`RPC_REG_ADDR_W-1:0] a);
    range_idx = a[`RPC_RANGE_STRIDE_SHIFT +: `RPC_RANGE_IDX_W];
  endfunction : range_idx

  // field within a range block
  function automatic logic [1:0] range_fld(
      input logic [`RPC_REG_ADDR_W-1:0] a);
    range_fld = a[3:2];
  endfunction : range_fld

  ////////////////////////////////////////////////////////////////////////////
  // power state synchroniser

  // two flops before the power level is used
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pwr_meta_ff <= 1'b0;
      pwr_sync_ff <= 1'b0;
    end else begin
      pwr_meta_ff <= periph_powered_i;
      pwr_sync_ff <= pwr_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // range comparators

  assign low_addr = xfer_i.addr[`RPC_ADDR_W-1:0]; // low word only

  // one comparator per range
  for (genvar g = 0; g < `RPC_NUM_RANGES; g++) begin : g_range
    rpc_range_match u_match (
      .start_i(start_ff[g]),
      .end_i(end_ff[g]),
      .attr_i(attr_ff[g]),
      .addr_i(low_addr),
      .priv_id_i(xfer_i.priv_id),
      .write_i(xfer_i.write),
      .exec_i(xfer_i.exec),
      .supervisor_i(xfer_i.supervisor),
      .hit_o(hit[g]),
      .permit_o(permit[g])
    );
  end

  // every hit range must permit, giving the per-type minimum
  assign all_permit = &permit;
  // a miss on all ranges permits since each permit bit is set
  assign refuse = xfer_valid_i && !all_permit;
  assign ack_wr = reg_wr_i && pwr_sync_ff &&
                  (reg_addr_i == `RPC_REG_EVENT_ACK) &&
                  (reg_wdata_i == `RPC_ZERO32);

  ////////////////////////////////////////////////////////////////////////////
  // transfer screening

  // forward allowed transfers, block refused ones
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slv_valid_ff <= 1'b0;
      slv_xfer_ff <= '0;
      block_ff <= 1'b0;
    end else begin
      slv_valid_ff <= xfer_valid_i && all_permit;
      slv_xfer_ff <= xfer_i; // passed through unchanged
      block_ff <= refuse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // violation event

  // level event held until a zero write to the ack register; set wins
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= RPC_IDLE;
      violation_ff <= 1'b0;
      fault_addr_ff <= `RPC_ADDR_RST;
      fault_stat_ff <= `RPC_ZERO32;
    end else begin
      case (state_ff)
        RPC_IDLE: begin
          if (refuse) begin
            state_ff <= RPC_FAULT;
            violation_ff <= 1'b1;
            fault_addr_ff <= low_addr;
            fault_stat_ff <= {24'h000000, xfer_i.supervisor, xfer_i.exec,
                              xfer_i.write, 1'b0, xfer_i.priv_id};
          end
        end
        RPC_FAULT: begin
          if (ack_wr && !refuse) begin
            state_ff <= RPC_IDLE;
            violation_ff <= 1'b0;
          end else if (ack_wr) begin
            fault_addr_ff <= low_addr;
          end
        end
        default: begin
          state_ff <= RPC_IDLE;
          violation_ff <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  // range settings, accepted only while the peripheral is powered
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < `RPC_NUM_RANGES; i++) begin
        start_ff[i] <= `RPC_ADDR_RST;
        end_ff[i] <= `RPC_ADDR_RST;
        attr_ff[i] <= `RPC_ATTR_RST;
      end
    end else if (reg_wr_i && pwr_sync_ff && range_sel(reg_addr_i)) begin
      case (range_fld(reg_addr_i))
        `RPC_OFS_START: start_ff[range_idx(reg_addr_i)] <= reg_wdata_i;
        `RPC_OFS_END: end_ff[range_idx(reg_addr_i)] <= reg_wdata_i;
        `RPC_OFS_ATTR: attr_ff[range_idx(reg_addr_i)] <= reg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads and error answer

  // read data one cycle later; unpowered access answers with error
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_ff <= `RPC_ZERO32;
      reg_err_ff <= 1'b0;
    end else begin
      reg_err_ff <= (reg_wr_i || reg_rd_i) && !pwr_sync_ff;
      reg_rdata_ff <= `RPC_ZERO32;
      if (reg_rd_i && pwr_sync_ff) begin
        if (range_sel(reg_addr_i)) begin
          case (range_fld(reg_addr_i))
            `RPC_OFS_START: reg_rdata_ff <= start_ff[range_idx(reg_addr_i)];
            `RPC_OFS_END: reg_rdata_ff <= end_ff[range_idx(reg_addr_i)];
            `RPC_OFS_ATTR: reg_rdata_ff <= attr_ff[range_idx(reg_addr_i)];
            default: reg_rdata_ff <= `RPC_ZERO32;
          endcase
        end else begin
          case (reg_addr_i)
            `RPC_REG_FAULT_ADDR: reg_rdata_ff <= fault_addr_ff;
            `RPC_REG_FAULT_STAT: reg_rdata_ff <= {fault_stat_ff[31:1],
                                                  violation_ff};
            `RPC_REG_ID: reg_rdata_ff <= `RPC_ID_CODE; // arbitrary value
            default: reg_rdata_ff <= `RPC_ZERO32;
          endcase
        end
      end
    end
  end

  assign reg_rdata_o = reg_rdata_ff;
  assign reg_err_o = reg_err_ff;
  assign slv_valid_o = slv_valid_ff;
  assign slv_xfer_o = slv_xfer_ff;
  assign xfer_block_o = block_ff;
  assign violation_o = violation_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // a transfer hitting no range passes the next cycle
  miss_passes_a: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    xfer_valid_i && (hit == '0) |=> slv_valid_o && !xfer_block_o)
    else $error("unmatched transfer was not passed");

  // a refused transfer never reaches the slave
  refused_blocked_a: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    refuse |=> !slv_valid_o && xfer_block_o && violation_o)
    else $error("refused transfer reached slave");

  // any failing hit range refuses the transfer
  overlap_all_a: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    xfer_valid_i && (permit != '1) |=> !slv_valid_o)
    else $error("overlap did not refuse");

  // violation holds until acknowledged
  event_held_a: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    violation_o && !ack_wr |=> violation_o)
    else $error("violation dropped without ack");

  // ack with no new refusal clears the event
  ack_clears_a: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    violation_o && ack_wr && !refuse |=> !violation_o)
    else $error("ack did not clear violation");

  // unpowered access answers with error next cycle
  unpowered_err_a: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (reg_rd_i || reg_wr_i) && !pwr_sync_ff |=> reg_err_o)
    else $error("missing bus error when unpowered");

  // deny-all attribute on range 0, when hit, refuses any id
  deny_all_a: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    xfer_valid_i && hit[0] && attr_ff[0] == `RPC_ATTR_DENY_ALL
    |=> xfer_block_o)
    else $error("deny-all range admitted access");

  // zero attribute never causes refusal
  zero_attr_a: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    attr_ff[0] == `RPC_ATTR_RST |-> permit[0])
    else $error("zero attribute refused access");

  // forwarded and blocked answers never stand together
  pass_or_block_a: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !(slv_valid_o && xfer_block_o))
    else $error("transfer both forwarded and blocked");

  // an unmatched transfer never raises the event from idle
  miss_no_event_a: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    !violation_o && xfer_valid_i && (hit == '0) |=> !violation_o)
    else $error("unmatched transfer raised violation");

endmodule : rpc_checker

//--- logic/rpc_params.svh
/*
  constants for the range protection checker: register offsets, field
  positions, reset values and sizes. assumes a 32-bit word register port.
*/
`ifndef RPC_PARAMS_SVH
`define RPC_PARAMS_SVH

`define RPC_NUM_RANGES 4
`define RPC_RANGE_IDX_W 2
`define RPC_NUM_IDS 16
`define RPC_ID_W 4
`define RPC_ADDR_W 32
`define RPC_WIDE_ADDR_W 36
`define RPC_REG_ADDR_W 8
`define RPC_DATA_W 32
// register map: per-range block of 16 bytes, start at 0x00
`define RPC_RANGE_BASE 8'h00
`define RPC_RANGE_STRIDE_SHIFT 4
`define RPC_OFS_START 2'h0
`define RPC_OFS_END 2'h1
`define RPC_OFS_ATTR 2'h2
`define RPC_RANGE_LIMIT 8'h40
`define RPC_REG_FAULT_ADDR 8'h80
`define RPC_REG_FAULT_STAT 8'h84
`define RPC_REG_EVENT_ACK 8'h88
`define RPC_REG_ID 8'h8C
// permission attribute fields
`define RPC_ATTR_UX 0
`define RPC_ATTR_UW 1
`define RPC_ATTR_UR 2
`define RPC_ATTR_SX 3
`define RPC_ATTR_SW 4
`define RPC_ATTR_SR 5
`define RPC_ATTR_ID_LSB 10
`define RPC_ATTR_DENY_ALL 32'h03FFFC00
`define RPC_ATTR_RST 32'h00000000
`define RPC_ADDR_RST 32'h00000000
`define RPC_ID_CODE 32'h0000A5C3
`define RPC_ZERO32 32'h00000000

`endif

//--- logic/rpc_pkg.sv
/*
  types shared by the range protection checker.
  assumes rpc_params.svh is on the include path.
*/
`include "rpc_params.svh"

package rpc_pkg;

  // one transfer presented on the slave port
  typedef struct packed {
    logic [`RPC_WIDE_ADDR_W-1:0] addr;
    logic [`RPC_ID_W-1:0] priv_id;
    logic write;
    logic exec;
    logic supervisor;
  } rpc_xfer_type;

  // checker verdict
  typedef struct packed {
    logic allow;
    logic hit_any;
  } rpc_verdict_type;

  typedef enum logic [1:0] {
    RPC_IDLE,
    RPC_FAULT
  } rpc_state_type;

endpackage : rpc_pkg

//--- logic/rpc_range_match.sv
/*
  one protection range: boundary compare and permission lookup.
  assumes the address given is already the low 32-bit part.
*/
`include "rpc_params.svh"

module rpc_range_match
  import rpc_pkg::*;
(
  // range settings
  input wire logic [`RPC_ADDR_W-1:0] start_i,
  input wire logic [`RPC_ADDR_W-1:0] end_i,
  input wire logic [`RPC_DATA_W-1:0] attr_i,
  // transfer
  input wire logic [`RPC_ADDR_W-1:0] addr_i,
  input wire logic [`RPC_ID_W-1:0] priv_id_i,
  input wire logic write_i,
  input wire logic exec_i,
  input wire logic supervisor_i,
  // verdict
  output logic hit_o,
  output logic permit_o
);

  logic in_range;
  logic id_checked;
  logic type_ok;

  // inclusive boundaries
  assign in_range = (addr_i >= start_i) && (addr_i <= end_i);
  // requestor bit selects whether this range checks the id
  assign id_checked = attr_i[`RPC_ATTR_ID_LSB + 32'(priv_id_i)];

  // per-type permission bit; read-only grants block writes
  always_comb begin
    if (supervisor_i) begin
      type_ok = write_i ? attr_i[`RPC_ATTR_SW] :
                exec_i ? attr_i[`RPC_ATTR_SX] : attr_i[`RPC_ATTR_SR];
    end else begin
      type_ok = write_i ? attr_i[`RPC_ATTR_UW] :
                exec_i ? attr_i[`RPC_ATTR_UX] : attr_i[`RPC_ATTR_UR];
    end
  end

  // zero attribute admits all, deny-all attribute refuses all
  assign hit_o = in_range;
  assign permit_o = !in_range || !id_checked || type_ok;

endmodule : rpc_range_match

//--- test/rpc_checker_bench.sv
/*
  self-checking bench for the range protection checker.
  assumes the master model in rpc_master_model.sv and the design files.
*/
`include "rpc_params.svh"

module rpc_checker_bench;
  import rpc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // permit sets: read only, read and write, read and execute
  localparam logic [31:0] P_RD = 32'h00000024;
  localparam logic [31:0] P_RW = 32'h00000036;
  localparam logic [31:0] P_RX = 32'h0000002D;
  localparam logic [7:0] ACK = `RPC_REG_EVENT_ACK;
  logic clk, rst, reg_wr, reg_rd, reg_err, powered, go, m_valid;
  logic slv_valid, blk, viol;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  rpc_xfer_type req, m_xfer, slv_xfer;
  int bad_count, checks_done, cycles;

  rpc_master_model master (.ref_clk_i(clk), .sys_rst_i(rst), .go_i(go),
    .req_i(req), .valid_o(m_valid), .xfer_o(m_xfer));
  rpc_checker dut (.ref_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .reg_err_o(reg_err),
    .periph_powered_i(powered), .xfer_valid_i(m_valid), .xfer_i(m_xfer),
    .slv_valid_o(slv_valid), .slv_xfer_o(slv_xfer), .xfer_block_o(blk),
    .violation_o(viol));

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : reg_write
  // read data and error stand only in the cycle after the strobe
  task reg_read(input logic [7:0] a, input logic [31:0] d, input logic e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, d);
    check(reg_err, e);
  endtask : reg_read
  task set_range(input logic [1:0] n, input logic [31:0] s, e, at);
    reg_write({2'b00, n, 4'h0}, s);
    reg_write({2'b00, n, 4'h4}, e);
    reg_write({2'b00, n, 4'h8}, at);
  endtask : set_range
  // one transfer through the master; answer looked at one cycle later
  task xfer(input logic [35:0] a, input logic [3:0] id,
            input logic w, x, s, pass);
    @(posedge clk);
    go <= 1'b1;
    req <= '{a, id, w, x, s};
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    check(slv_valid, pass);
    check(blk, !pass);
    if (pass) check(slv_xfer, {a, id, w, x, s});
  endtask : xfer
  task final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, go} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    req = '0;
    bad_count = 0;
    checks_done = 0;
    cycles = 0;
    powered = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int n = 0; n < 12; n++) reg_read(8'(n * 4), 32'h0, 1'b0);
    reg_read(`RPC_REG_ID, `RPC_ID_CODE, 1'b0);
    reg_read(`RPC_RANGE_LIMIT, 32'h0, 1'b0);
    xfer(36'h0_0000_1234, 4'h2, 1'b1, 1'b0, 1'b1, 1'b1);
    check(viol, 1'b0);
    $display("test reset_and_unmatched done");
    set_range(2'd0, 32'h1000, 32'h1FFF, 32'h0);
    for (int i = 0; i < 8; i++)
      xfer(36'h1800, 4'(i), i[0], i[1], i[2], 1'b1);
    reg_write(8'h08, `RPC_ATTR_DENY_ALL);
    xfer(36'h0FFF, 4'h3, 1'b0, 1'b0, 1'b1, 1'b1);
    xfer(36'h1000, 4'h3, 1'b0, 1'b0, 1'b1, 1'b0);
    check(viol, 1'b1);
    reg_read(`RPC_REG_FAULT_ADDR, 32'h1000, 1'b0);
    reg_read(`RPC_REG_FAULT_STAT, 32'h00000083, 1'b0);
    for (int i = 0; i < 8; i++)
      xfer(36'h1800, 4'(i), i[0], i[1], i[2], 1'b0);
    xfer(36'h1FFF, 4'h9, 1'b0, 1'b0, 1'b0, 1'b0);
    xfer(36'h2000, 4'h9, 1'b0, 1'b0, 1'b0, 1'b1);
    xfer(36'hF_0000_1800, 4'h1, 1'b1, 1'b0, 1'b0, 1'b0);
    xfer(36'hF_0000_2000, 4'h1, 1'b1, 1'b0, 1'b0, 1'b1);
    reg_write(ACK, 32'h1);
    check(viol, 1'b1);
    reg_write(ACK, 32'h0);
    check(viol, 1'b0);
    $display("test deny_all_and_event done");
    reg_write(8'h08, (32'h1 << 15) | P_RD);
    xfer(36'h1100, 4'h5, 1'b0, 1'b0, 1'b1, 1'b1);
    xfer(36'h1100, 4'h5, 1'b0, 1'b0, 1'b0, 1'b1);
    xfer(36'h1100, 4'h5, 1'b1, 1'b0, 1'b1, 1'b0);
    xfer(36'h1100, 4'h5, 1'b1, 1'b0, 1'b0, 1'b0);
    xfer(36'h1100, 4'h5, 1'b0, 1'b1, 1'b1, 1'b0);
    xfer(36'h1100, 4'h4, 1'b1, 1'b0, 1'b0, 1'b1);
    reg_write(ACK, 32'h0);
    $display("test requestor_lookup done");
    set_range(2'd0, 32'h1000, 32'h1FFF, (32'h1 << 13) | P_RW);
    set_range(2'd3, 32'h1800, 32'h27FF, (32'h1 << 13) | P_RX);
    xfer(36'h1900, 4'h3, 1'b0, 1'b0, 1'b1, 1'b1);
    xfer(36'h1900, 4'h3, 1'b1, 1'b0, 1'b1, 1'b0);
    xfer(36'h1900, 4'h3, 1'b0, 1'b1, 1'b0, 1'b0);
    xfer(36'h1100, 4'h3, 1'b1, 1'b0, 1'b1, 1'b1);
    xfer(36'h2100, 4'h3, 1'b0, 1'b1, 1'b1, 1'b1);
    xfer(36'h2100, 4'h3, 1'b1, 1'b0, 1'b0, 1'b0);
    reg_write(ACK, 32'h0);
    $display("test overlap done");
    for (int i = 0; i < 16; i++) begin
      reg_write(8'h08, 32'h1 << (10 + i));
      xfer(36'h1100, 4'(i), 1'b0, 1'b0, 1'b1, 1'b0);
      xfer(36'h1100, 4'(i + 1), 1'b0, 1'b0, 1'b1, 1'b1);
    end
    reg_write(ACK, 32'h0);
    check(viol, 1'b0);
    $display("test all_ids done");
    @(posedge clk);
    powered <= 1'b0;
    repeat (4) @(posedge clk);
    reg_read(8'h08, 32'h0, 1'b1);
    reg_write(8'h08, 32'h0);
    check(reg_err, 1'b1);
    @(posedge clk);
    powered <= 1'b1;
    repeat (4) @(posedge clk);
    reg_read(8'h08, 32'h1 << 25, 1'b0);
    $display("test unpowered_access done");
    final_report();
  end
endmodule : rpc_checker_bench

//--- test/rpc_master_model.sv
/*
  behavioural bus master that presents one transfer a cycle to the checker.
  assumes the bench raises go_i for one cycle per transfer, after an edge.
*/
module rpc_master_model
  import rpc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // request from the bench
  input wire logic go_i,
  input wire rpc_xfer_type req_i,
  // transfer towards the checker
  output logic valid_o,
  output rpc_xfer_type xfer_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // a released bus inverts every bit each cycle, showing the last transfer every second cycle
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      valid_o <= 1'b0;
      xfer_o <= '0;
    end else begin
      valid_o <= go_i;
      xfer_o <= go_i ? req_i : ~xfer_o;
    end
  end
endmodule : rpc_master_model
